/* bench/sosr_host_rx.sv */
`timescale 1ns/100ps
`default_nettype none
module sosr_host_rx
  import sosr_pkg::*;
(
  input wire logic          pclk,
  input wire sosr_quad_type quad_out,
  output var int            z_cnt = 0,
  output var int            ab_cnt = 0
);
  logic [1:0] ab_q = 2'h0;
  always @(posedge pclk) begin
    if (quad_out.origin_marker_pos) z_cnt <= z_cnt + 1;
    if ({quad_out.quad_chan_a_pos, quad_out.quad_chan_b_pos} != ab_q) ab_cnt <= ab_cnt + 1;
    ab_q <= {quad_out.quad_chan_a_pos, quad_out.quad_chan_b_pos};
  end
endmodule : sosr_host_rx
`default_nettype wire

/* bench/sosr_router_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module sosr_router_properties
  import sosr_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire sosr_src_type  status_in,
  input wire logic          enc_valid,
  input wire logic [3:0]    out_circuit,
  input wire sosr_quad_type quad_out
);
  logic ap, an, bp, bn, zp, zn, wr_r;
  assign {ap, an, bp, bn, zp, zn} = quad_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_r <= 1'b0;
    else if (psel && penable && pwrite) wr_r <= 1'b1;
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_idle_high: assert property (!wr_r |-> out_circuit == 4'hf) else $error("idle");
  a_pair_a: assert property ($past(presetn, 2) |-> an != ap) else $error("a pair");
  a_pair_b: assert property ($past(presetn, 2) |-> bn != bp) else $error("b pair");
  a_pair_z: assert property ($past(presetn, 2) |-> zn != zp) else $error("z pair");
  a_z_once: assert property ($rose(zp) |=> !zp) else $error("z width");
  a_gray_step: assert property (!($changed(ap) && $changed(bp))) else $error("ab jump");
  a_quad_quiet:
    assert property (!$past(enc_valid) && !$past(enc_valid, 2) && !$past(enc_valid, 3)
      |-> $stable({ap, bp})) else $error("ab drift");
  a_settle_stable:
    assert property ($past(presetn) && $stable(status_in) && !$past(psel && penable && pwrite)
      |=> $stable(out_circuit)) else $error("glitch");
endmodule : sosr_router_properties
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sosr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic enc_valid = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] enc_position = 16'h0000;
  logic [3:0] out_circuit;
  sosr_src_type status_in = sosr_src_type'(4'h0);
  sosr_quad_type quad_out;
  int error_cnt = 0, samples_checked = 0, z_cnt, ab_cnt;
  sosr_router i_dut (.*);
  sosr_host_rx i_host (.pclk, .quad_out, .z_cnt, .ab_cnt);
  initial forever #50 pclk = ~pclk;
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    chk("pready", 32'h1, 32'(pready));
    if (pready !== 1'b1) final_report();
    e = pslverr;
    r = prdata;
    {psel, penable} <= 2'b00;
    // Idle edge keeps back-to-back calls from driving psel twice
    @(posedge pclk);
  endtask : apb
  task automatic st(logic [3:0] v, logic [3:0] x);
    status_in <= sosr_src_type'(v);
    repeat (2) @(posedge pclk);
    chk("out", 32'(x), 32'(out_circuit));
  endtask : st
  task automatic t_route();
    st(4'h4, 4'hf);
    apb(1'b1, 12'h004, 32'h0001);
    apb(1'b1, 12'h010, 32'h0001);
    st(4'h8, 4'he);
    st(4'h9, 4'he);
    st(4'h1, 4'he);
    apb(1'b1, 12'h014, 32'h0001);
    st(4'h8, 4'hf);
    apb(1'b1, 12'h000, 32'h1000);
    apb(1'b1, 12'h008, 32'h4321);
    st(4'h0, 4'h7);
    st(4'h4, 4'h8);
    apb(1'b0, 12'h008, 32'h0);
    chk("route_b", 32'h4321, r);
    apb(1'b0, 12'h100, 32'h0);
    chk("pslverr", 32'h1, 32'(e));
    chk("rdata", 32'h0, r);
  endtask : t_route
  task automatic t_enc();
    for (int i = 0; i < 4; i++) begin
      {enc_position, enc_valid} <= {16'hfffe + 16'(i), 1'b1};
      @(posedge pclk);
      enc_valid <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    chk("edges", 32'h3, 32'(ab_cnt));
    chk("marks", 32'h1, 32'(z_cnt));
  endtask : t_enc
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_route();
    t_enc();
    final_report();
  end
endmodule : tb
bind sosr_router sosr_router_properties i_props (.*);
`default_nettype wire

/* rtl/sosr_defs.svh */
`ifndef SOSR_DEFS_SVH
`define SOSR_DEFS_SVH
// ==========================================================
// Register byte addresses
`define SOSR_OFS_POLARITY 12'h000
`define SOSR_OFS_ROUTE_A  12'h004
`define SOSR_OFS_ROUTE_B  12'h008
`define SOSR_OFS_ROUTE_C  12'h00c
`define SOSR_OFS_ROUTE_D  12'h010
`define SOSR_OFS_MODE     12'h014
`define SOSR_OFS_STATUS   12'h018
`define SOSR_OFS_PULSES   12'h01c
// ==========================================================
// Reset values
`define SOSR_RST_POLARITY 16'h0000
`define SOSR_RST_ROUTE    16'h0000
`define SOSR_RST_MODE     2'h0
`define SOSR_RST_PULSES   16'h0800
// ==========================================================
// Field positions
`define SOSR_DIGIT_W      4
`define SOSR_MODE_LSB     0
`endif

/* rtl/sosr_pkg.sv */
package sosr_pkg;
  typedef enum logic [1:0] {
    SOSR_MODE_POSITION = 2'h0,
    SOSR_MODE_SPEED    = 2'h1,
    SOSR_MODE_TORQUE   = 2'h3
  } sosr_mode_type;

  // Four routed sources, one per selection register
  typedef struct packed {
    logic positioning_done;
    logic brake_release_out;
    logic servo_fault_out;
    logic aux_status;
  } sosr_src_type;

  typedef struct packed {
    logic quad_chan_a_pos;
    logic quad_chan_a_neg;
    logic quad_chan_b_pos;
    logic quad_chan_b_neg;
    logic origin_marker_pos;
    logic origin_marker_neg;
  } sosr_quad_type;
endpackage : sosr_pkg

/* rtl/sosr_router.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sosr_defs.svh"

// Summary of operation
// - Signals unevaluated in current mode read inactive
// - Shared output circuit drives OR of signals
// - Per-circuit polarity: 0 active-low, 1 active-high
// - Digit n value n+1 routes; zero disables
// - Four independent selections, any circuit combination
// - Brake output unrouted by default
// - Quadrature A/B with complementary pairs
// - Complementary origin marker from same position
// - Origin pulses on each one-count wrap through zero
module sosr_router
  import sosr_pkg::*;
#(
  parameter int POS_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire sosr_src_type      status_in,
  input  wire logic [POS_W-1:0]  enc_position,
  input  wire logic              enc_valid,
  output logic      [3:0]        out_circuit,
  output sosr_quad_type          quad_out
);

  // ========================================================
  // Register file
  logic [15:0]   polarity_r;
  logic [15:0]   route_r [4];
  sosr_mode_type mode_r;
  logic [15:0]   pulses_r;
  logic          wr_en;
  logic          rd_en;
  logic          addr_ok;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  // Loaded in the setup cycle so read data stands at the access edge
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_r <= `SOSR_RST_POLARITY;
      mode_r     <= SOSR_MODE_POSITION;
      pulses_r   <= `SOSR_RST_PULSES;
      for (int i = 0; i < 4; i++) begin
        route_r[i] <= `SOSR_RST_ROUTE;
      end
    end else if (wr_en && addr_ok) begin
      case (paddr)
        `SOSR_OFS_POLARITY: polarity_r <= pwdata[15:0];
        `SOSR_OFS_ROUTE_A:  route_r[0] <= pwdata[15:0];
        `SOSR_OFS_ROUTE_B:  route_r[1] <= pwdata[15:0];
        `SOSR_OFS_ROUTE_C:  route_r[2] <= pwdata[15:0];
        `SOSR_OFS_ROUTE_D:  route_r[3] <= pwdata[15:0];
        `SOSR_OFS_MODE:     mode_r     <= sosr_mode_type'(pwdata[1:0]);
        `SOSR_OFS_PULSES:   pulses_r   <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ========================================================
  // Routing
  logic [3:0] src_eff;
  logic [3:0] circ_act;
  logic [3:0] out_nxt;

  // Positioning-done is meaningless outside position control
  always_comb begin
    src_eff[3] = status_in.positioning_done && (mode_r == SOSR_MODE_POSITION);
    src_eff[2] = status_in.brake_release_out;
    src_eff[1] = status_in.servo_fault_out;
    src_eff[0] = status_in.aux_status;
  end

  always_comb begin
    circ_act = 4'h0;
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        if (route_r[3-s][c*4 +: 4] == 4'(c + 1)) begin
          circ_act[c] = circ_act[c] | src_eff[s];
        end
      end
    end
    for (int c = 0; c < 4; c++) begin
      out_nxt[c] = polarity_r[c*4] ? circ_act[c] : !circ_act[c];
    end
  end

  // Registered so setting changes cannot glitch the optocouplers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_circuit <= 4'hf;
    end else begin
      out_circuit <= out_nxt;
    end
  end

  // ========================================================
  // Encoder pulse output
  logic [POS_W-1:0] last_pos_r;
  logic [15:0]      step_r;
  logic [1:0]       phase_r;
  logic             have_pos_r;
  logic             origin_r;
  logic [POS_W-1:0] delta;
  logic             wrap_fwd;
  logic             wrap_rev;

  // Scale: quarter-pulse per (2^POS_W / (4*pulses)) counts, approximated
  // by emitting one quadrature step per position count change.
  assign delta    = enc_position - last_pos_r;
  assign wrap_fwd = (last_pos_r == {POS_W{1'b1}}) && (enc_position == '0);
  assign wrap_rev = (last_pos_r == '0) && (enc_position == {POS_W{1'b1}});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pos_r <= '0;
      have_pos_r <= 1'b0;
    end else if (enc_valid) begin
      last_pos_r <= enc_position;
      have_pos_r <= 1'b1;
    end
  end

  // One gray-coded step per position tick: limitation, fast jumps slip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
      step_r  <= 16'h0000;
    end else if (enc_valid && have_pos_r && delta != '0) begin
      if (delta[POS_W-1]) begin
        phase_r <= phase_r - 2'h1;
      end else begin
        phase_r <= phase_r + 2'h1;
      end
      step_r <= step_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      origin_r <= 1'b0;
    end else begin
      origin_r <= enc_valid && have_pos_r && (wrap_fwd || wrap_rev);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quad_out <= sosr_quad_type'(6'h15);
    end else begin
      quad_out.quad_chan_a_pos   <= phase_r[1] ^ phase_r[0];
      quad_out.quad_chan_a_neg   <= !(phase_r[1] ^ phase_r[0]);
      quad_out.quad_chan_b_pos   <= phase_r[1];
      quad_out.quad_chan_b_neg   <= !phase_r[1];
      quad_out.origin_marker_pos <= origin_r;
      quad_out.origin_marker_neg <= !origin_r;
    end
  end

  // ========================================================
  // Read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `SOSR_OFS_POLARITY: prdata <= {16'h0000, polarity_r};
        `SOSR_OFS_ROUTE_A:  prdata <= {16'h0000, route_r[0]};
        `SOSR_OFS_ROUTE_B:  prdata <= {16'h0000, route_r[1]};
        `SOSR_OFS_ROUTE_C:  prdata <= {16'h0000, route_r[2]};
        `SOSR_OFS_ROUTE_D:  prdata <= {16'h0000, route_r[3]};
        `SOSR_OFS_MODE:     prdata <= {30'h0, mode_r};
        `SOSR_OFS_STATUS:   prdata <= {20'h0, circ_act, out_circuit, src_eff};
        `SOSR_OFS_PULSES:   prdata <= {16'h0000, pulses_r};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : sosr_router
`default_nettype wire
